// [design/boil_pkg.sv]
// Constants, types and state layout of the boil power regulator.
//////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Operating mode is kept in storage and resumed; mash lamp off in boil mode.
// - Without a sensor show the open-sensor text and keep the heater off.
// - Boil mode bottom display shows boil output percent with a P marker.
// - In boil mode knob rotation changes boil output, applied with no press.
// - Start in acceleration with solid output; past threshold use boil output.
// - Boil output changed during acceleration shows at once, applies after it.
// - Acceleration threshold of zero skips acceleration entirely.
// - Until the temperature passes the acceleration threshold drive at the acceleration output power.
// - Acceleration output power is a percent from 0 to 100, initially 100.
// - Enter parameter setting after holding the knob five seconds; show group prompt.
// - Four groups; rotation cycles through them, press enters the shown one; press on the alarm group returns to run.
// - Clockwise increments, anticlockwise decrements, fast uses bigger steps, press advances.
// - All parameters are kept in nonvolatile storage.
// - Timer master enable, initially on, gates the timer in both modes.
// - Timer direction selects down or up counting, initially down.
// - Signed input offset within plus or minus 100, initially 0, added to temperature.
// - Unit setting selects Celsius or Fahrenheit, initially Fahrenheit.
// - Mash timer duration ranges 0 to 99:59, initially one hour.
// - Timer starts at the begin temperature and keeps counting afterwards.
// - Short press opens reset menu at no; one click gives yes; press restarts timer.
// - Running timer alternates temperature and time every six seconds; colon flashes.
// - Timer end gives six long beeps, meanwhile alternating temperature and end text.
// - After the end the boil finish choice keeps the output on or forces it off; the mash finish choice is not used.
// - Each rise above the buzzer setpoint gives four short beeps, unless the timer ends in that cycle; mash setpoint 150.
//////////////////////////////////////////////////////////////////////////////////////////
package boil_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int SLOT_MS = 20;
   localparam int SLOT_CYC = CLK_HZ / 1000 * SLOT_MS;
   localparam int HOLD_S = 5;
   localparam int ALT_S = 6;
   localparam int MIN_S = 60;
   localparam int BLINK_MS = 500;
   localparam int LONG_MS = 500;
   localparam int SHORT_MS = 100;
   localparam int HOLD_TK = HOLD_S * 1000 / TICK_MS;
   localparam int ALT_TK = ALT_S * 1000 / TICK_MS;
   localparam int MIN_TK = MIN_S * 1000 / TICK_MS;
   localparam int BLINK_TK = BLINK_MS / TICK_MS;
   localparam int LONG_TK = LONG_MS / TICK_MS;
   localparam int SHORT_TK = SHORT_MS / TICK_MS;
   localparam int CW = 24;
   localparam int PW = 15;
   localparam int NPAR = 16;
   localparam int PWM_SLOTS = 100;
   localparam int STEP_FAST = 10;
   localparam int BEEP_END = 6;
   localparam int BEEP_ALARM = 4;
   localparam int F_MUL = 9;
   localparam int F_DIV = 5;
   localparam int F_OFS = 32;
   // Parameter indices.
   localparam int P_TEN = 0, P_TDIR = 1, P_OFS = 2, P_UNIT = 3;
   localparam int P_MTIME = 4, P_MBEG = 5, P_MALM = 6, P_MFIN = 7;
   localparam int P_ATHR = 8, P_AOUT = 9, P_BTIME = 10, P_BBEG = 11;
   localparam int P_BALM = 12, P_BFIN = 13, P_BOUT = 14, P_MODE = 15;
   localparam int P_MIN [NPAR] = '{0, 0, -100, 0, 0, -999, -999, 0,
                                   -999, 0, 0, -999, -999, 0, 0, 0};
   localparam int P_MAX [NPAR] = '{1, 1, 100, 1, 5999, 9999, 9999, 1,
                                   9999, 100, 5999, 9999, 9999, 1, 100, 1};
   localparam int P_INIT [NPAR] = '{1, 0, 0, 1, 60, 151, 150, 0,
                                    200, 100, 60, 208, 200, 0, 50, 0};
   // Groups: mash, boil, alarm, system.
   localparam logic [1:0] G_ALAM = 2'h2;
   localparam int G_FIRST [4] = '{P_MTIME, P_ATHR, 0, P_TEN};
   localparam int G_LAST [4] = '{P_MFIN, P_BFIN, 0, P_UNIT};
   localparam logic [1:0] SEL_NO = 2'h0, SEL_YES = 2'h1, SEL_MASH = 2'h2, SEL_BOIL = 2'h3;

   typedef enum logic [1:0] {UI_RUN, UI_RST, UI_GROUP, UI_EDIT} ui_t;
   typedef enum logic [2:0] {TOP_TEMP, TOP_TIME, TOP_OPEN, TOP_END, TOP_RST, TOP_MODE,
                             TOP_GOTO, TOP_PNAME} top_t;
   typedef enum logic [2:0] {BOT_POWER, BOT_SETPT, BOT_NO, BOT_YES, BOT_MASH, BOT_BOIL,
                             BOT_GROUP, BOT_VALUE} bot_t;

   typedef struct packed {
      ui_t ui;
      logic [NPAR-1:0][PW-1:0] par;
      logic [3:0] idx;
      logic [1:0] grp;
      logic [1:0] sel;
      logic press_q;
      logic wait_rel;
      logic [7:0] hold;
      logic [CW-1:0] tick_cnt;
      logic [CW-1:0] slot_cnt;
      logic [6:0] slot;
      logic accel;
      logic above_q;
      logic t_run;
      logic done;
      logic [9:0] tsub;
      logic [PW-1:0] elapsed;
      logic [6:0] alt;
      logic alt_t;
      logic [3:0] blk;
      logic blink;
      logic [2:0] beeps;
      logic beep_long;
      logic beep_on;
      logic [3:0] beep_tk;
      logic relay;
      logic mash_led;
      logic colon;
      logic nv_we;
      logic [3:0] nv_idx;
      logic [PW-1:0] nv_data;
      top_t top;
      bot_t bot;
      logic [PW-1:0] bval;
      logic [PW-1:0] tval;
      logic [PW-1:0] time_v;
   } st_t;

   function automatic st_t init_st();
      st_t s;
      s = '0;
      for (int i = 0; i < NPAR; i++)
      begin
         s.par[i] = PW'(P_INIT[i]);
      end
      s.accel = 1'b1;
      return s;
   endfunction
endpackage

// [design/boil_power_regulator_timer.sv]
// Boil mode power regulator with menu, timer, buzzer and relay pulse output.
`timescale 1ns/100ps
module boil_power_regulator_timer import boil_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC, // Cycles per 100 ms tick.
   parameter int SLOT_CYCLES = SLOT_CYC  // Cycles per output pulse slot.
) (
   input wire logic i_clk,                   // System clock.
   input wire logic i_rst_n,                 // Synchronous reset, active low.
   input wire logic i_knob_cw,               // One clockwise detent, pulse.
   input wire logic i_knob_ccw,              // One anticlockwise detent, pulse.
   input wire logic i_knob_fast,             // Fast rotation, with a detent.
   input wire logic i_knob_press,            // Knob pressed, level.
   input wire logic i_sensor_ok,             // Sensor present, level.
   input wire logic signed [11:0] i_temp_c,  // Measured temperature, Celsius.
   input wire logic i_nv_load,               // Stored value restore strobe.
   input wire logic [3:0] i_nv_idx,          // Restored parameter index.
   input wire logic [PW-1:0] i_nv_data,      // Restored parameter value.
   output logic o_nv_we,                     // Parameter store strobe.
   output logic [3:0] o_nv_idx,              // Stored parameter index.
   output logic [PW-1:0] o_nv_data,          // Stored parameter value.
   output logic o_relay,                     // Relay drive.
   output logic o_out_led,                   // Output lamp.
   output logic o_mash_led,                  // Mashing mode lamp.
   output logic o_buzzer,                    // Buzzer drive.
   output top_t o_top,                       // Top display content.
   output bot_t o_bot,                       // Bottom display content.
   output logic [PW-1:0] o_bot_val,          // Bottom display number.
   output logic [PW-1:0] o_temp,             // Corrected temperature.
   output logic [PW-1:0] o_time,             // Timer minutes shown.
   output logic o_colon,                     // Time colon lit.
   output logic [3:0] o_par_idx              // Parameter being edited.
);
   st_t st_ff;
   st_t nxt_st;
   logic tick;
   logic slot_end;
   logic mash;
   logic rise;
   logic signed [15:0] tc;
   logic signed [15:0] tf;
   logic signed [15:0] tv;
   logic signed [PW-1:0] temp;
   logic signed [PW-1:0] dur_v;
   logic signed [PW-1:0] beg_v;
   logic signed [PW-1:0] alm_v;
   logic signed [15:0] step;

   function automatic logic [PW-1:0] clamp(input logic signed [15:0] v, input int k);
      logic [PW-1:0] r;
      r = PW'(v);
      if (v < 16'(P_MIN[k]))
      begin
         r = PW'(P_MIN[k]);
      end
      else if (v > 16'(P_MAX[k]))
      begin
         r = PW'(P_MAX[k]);
      end
      return r;
   endfunction

   //////////////////////////////////////////////////////////////////////////////////////
   assign tick = st_ff.tick_cnt == CW'(TICK_CYCLES - 1);
   assign slot_end = st_ff.slot_cnt == CW'(SLOT_CYCLES - 1);
   assign mash = st_ff.par[P_MODE][0];
   assign rise = i_knob_press && !st_ff.press_q && !st_ff.wait_rel;
   assign tc = 16'(i_temp_c);
   assign tf = 16'(tc * 16'(F_MUL) / 16'(F_DIV) + 16'(F_OFS));
   assign tv = (st_ff.par[P_UNIT][0] ? tf : tc) + 16'($signed(st_ff.par[P_OFS]));
   assign temp = PW'(tv);
   assign dur_v = $signed(st_ff.par[mash ? P_MTIME : P_BTIME]);
   assign beg_v = $signed(st_ff.par[mash ? P_MBEG : P_BBEG]);
   assign alm_v = $signed(st_ff.par[mash ? P_MALM : P_BALM]);
   assign step = i_knob_fast ? 16'(STEP_FAST) : 16'sd1;

   //////////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic wv;
      logic [3:0] wi;
      logic [PW-1:0] wd;
      logic signed [15:0] cur;
      logic [6:0] pw;
      wv = 1'b0;
      wi = st_ff.idx;
      wd = '0;
      cur = 16'($signed(st_ff.par[st_ff.idx]));
      pw = '0;
      nxt_st = st_ff;
      nxt_st.nv_we = 1'b0;
      nxt_st.press_q = i_knob_press;
      nxt_st.tick_cnt = tick ? '0 : st_ff.tick_cnt + 1'b1;
      nxt_st.slot_cnt = slot_end ? '0 : st_ff.slot_cnt + 1'b1;
      if (slot_end)
      begin
         nxt_st.slot = (st_ff.slot == 7'(PWM_SLOTS - 1)) ? '0 : st_ff.slot + 1'b1;
      end
      if (tick)
      begin
         nxt_st.blk = (st_ff.blk == 4'(BLINK_TK - 1)) ? '0 : st_ff.blk + 1'b1;
         nxt_st.blink = st_ff.blink ^ (st_ff.blk == 4'(BLINK_TK - 1));
         nxt_st.alt = (st_ff.alt == 7'(ALT_TK - 1)) ? '0 : st_ff.alt + 1'b1;
         nxt_st.alt_t = st_ff.alt_t ^ (st_ff.alt == 7'(ALT_TK - 1));
      end
      if (i_nv_load)
      begin
         nxt_st.par[i_nv_idx] = i_nv_data;
      end
      if (!mash && (st_ff.par[P_ATHR] == '0 || temp > $signed(st_ff.par[P_ATHR])))
      begin
         nxt_st.accel = 1'b0;
      end
      // Beeper sequencer: equal on and off phases per beep.
      if (tick && st_ff.beeps != '0)
      begin
         nxt_st.beep_tk = st_ff.beep_tk + 1'b1;
         if (st_ff.beep_tk == 4'((st_ff.beep_long ? LONG_TK : SHORT_TK) - 1))
         begin
            nxt_st.beep_tk = '0;
            nxt_st.beep_on = !st_ff.beep_on;
            if (st_ff.beep_on)
            begin
               nxt_st.beeps = st_ff.beeps - 1'b1;
            end
         end
      end
      nxt_st.above_q = temp > alm_v;
      if (i_sensor_ok && temp > alm_v && !st_ff.above_q)
      begin
         nxt_st.beeps = 3'(BEEP_ALARM);
         nxt_st.beep_long = 1'b0;
         nxt_st.beep_on = 1'b1;
         nxt_st.beep_tk = '0;
      end
      if (st_ff.par[P_TEN][0])
      begin
         if (!st_ff.t_run && !st_ff.done && i_sensor_ok && temp >= beg_v)
         begin
            nxt_st.t_run = 1'b1;
         end
         if (st_ff.t_run && tick)
         begin
            nxt_st.tsub = (st_ff.tsub == 10'(MIN_TK - 1)) ? '0 : st_ff.tsub + 1'b1;
            nxt_st.elapsed = st_ff.elapsed + PW'(st_ff.tsub == 10'(MIN_TK - 1));
         end
         if (st_ff.t_run && $signed(st_ff.elapsed) >= dur_v)
         begin
            nxt_st.t_run = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.beeps = 3'(BEEP_END);
            nxt_st.beep_long = 1'b1;
            nxt_st.beep_on = 1'b1;
            nxt_st.beep_tk = '0;
         end
      end
      // Knob press: a hold ends in the menu and must be released before the next press.
      if (!i_knob_press)
      begin
         nxt_st.wait_rel = 1'b0;
         nxt_st.hold = '0;
      end
      else if (tick && st_ff.hold != 8'hff)
      begin
         nxt_st.hold = st_ff.hold + 1'b1;
      end
      case (st_ff.ui)
         UI_RUN:
         begin
            if (!mash && (i_knob_cw || i_knob_ccw))
            begin
               wv = 1'b1;
               wi = 4'(P_BOUT);
               cur = 16'($signed(st_ff.par[P_BOUT]));
               wd = clamp(i_knob_cw ? cur + step : cur - step, P_BOUT);
            end
            if (i_knob_press && !st_ff.wait_rel && st_ff.hold >= 8'(HOLD_TK))
            begin
               nxt_st.ui = UI_GROUP;
               nxt_st.wait_rel = 1'b1;
               nxt_st.grp = '0;
            end
            else if (!i_knob_press && st_ff.press_q && !st_ff.wait_rel)
            begin
               nxt_st.ui = UI_RST;
               nxt_st.sel = SEL_NO;
            end
         end
         UI_RST:
         begin
            if (i_knob_cw && st_ff.sel != SEL_BOIL)
            begin
               nxt_st.sel = st_ff.sel + 1'b1;
            end
            else if (i_knob_ccw && st_ff.sel != SEL_NO)
            begin
               nxt_st.sel = st_ff.sel - 1'b1;
            end
            if (rise)
            begin
               nxt_st.ui = UI_RUN;
               nxt_st.wait_rel = 1'b1;
               if (st_ff.sel == SEL_YES)
               begin
                  nxt_st.t_run = st_ff.par[P_TEN][0];
                  nxt_st.done = 1'b0;
                  nxt_st.elapsed = '0;
                  nxt_st.tsub = '0;
               end
               else if (st_ff.sel != SEL_NO)
               begin
                  wv = 1'b1;
                  wi = 4'(P_MODE);
                  wd = PW'(st_ff.sel == SEL_MASH);
                  nxt_st.accel = st_ff.par[P_ATHR] != '0;
               end
            end
         end
         UI_GROUP:
         begin
            nxt_st.grp = st_ff.grp + 2'(i_knob_cw) - 2'(i_knob_ccw);
            if (rise)
            begin
               nxt_st.ui = (st_ff.grp == G_ALAM) ? UI_RUN : UI_EDIT;
               nxt_st.wait_rel = 1'b1;
               nxt_st.idx = 4'(G_FIRST[st_ff.grp]);
            end
         end
         UI_EDIT:
         begin
            if (i_knob_cw || i_knob_ccw)
            begin
               wv = 1'b1;
               wd = clamp(i_knob_cw ? cur + step : cur - step, int'(st_ff.idx));
            end
            if (rise)
            begin
               nxt_st.idx = st_ff.idx + 1'b1;
               nxt_st.wait_rel = 1'b1;
               if (st_ff.idx == 4'(G_LAST[st_ff.grp]))
               begin
                  nxt_st.ui = UI_RUN;
               end
            end
         end
         default:
         begin
            nxt_st.ui = UI_RUN;
         end
      endcase
      if (wv)
      begin
         nxt_st.par[wi] = wd;
         nxt_st.nv_we = 1'b1;
         nxt_st.nv_idx = wi;
         nxt_st.nv_data = wd;
      end
      // Outputs.
      pw = st_ff.accel ? st_ff.par[P_AOUT][6:0] : st_ff.par[P_BOUT][6:0];
      nxt_st.relay = i_sensor_ok && !mash && !(st_ff.done && !st_ff.par[P_BFIN][0])
                     && st_ff.slot < pw;
      nxt_st.mash_led = mash;
      nxt_st.tval = temp;
      nxt_st.time_v = st_ff.par[P_TDIR][0] ? st_ff.elapsed
                      : PW'(dur_v - $signed(st_ff.elapsed));
      nxt_st.colon = 1'b0;
      nxt_st.bval = st_ff.par[P_BOUT];
      nxt_st.bot = mash ? BOT_SETPT : BOT_POWER;
      nxt_st.top = TOP_TEMP;
      case (st_ff.ui)
         UI_RUN:
         begin
            if (!i_sensor_ok)
            begin
               nxt_st.top = TOP_OPEN;
            end
            else if (st_ff.done)
            begin
               nxt_st.top = st_ff.alt_t ? TOP_END : TOP_TEMP;
            end
            else if (st_ff.t_run && st_ff.par[P_TEN][0] && st_ff.alt_t)
            begin
               nxt_st.top = TOP_TIME;
               nxt_st.colon = st_ff.blink;
            end
         end
         UI_RST:
         begin
            nxt_st.top = (st_ff.sel >= SEL_MASH) ? TOP_MODE : TOP_RST;
            nxt_st.bot = bot_t'(3'(BOT_NO) + 3'(st_ff.sel));
         end
         UI_GROUP:
         begin
            nxt_st.top = TOP_GOTO;
            nxt_st.bot = BOT_GROUP;
            nxt_st.bval = PW'(st_ff.grp);
         end
         default:
         begin
            nxt_st.top = TOP_PNAME;
            nxt_st.bot = BOT_VALUE;
            nxt_st.bval = st_ff.par[st_ff.idx];
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         st_ff <= init_st();
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign o_nv_we = st_ff.nv_we;
   assign o_nv_idx = st_ff.nv_idx;
   assign o_nv_data = st_ff.nv_data;
   assign o_relay = st_ff.relay;
   assign o_out_led = st_ff.relay;
   assign o_mash_led = st_ff.mash_led;
   assign o_buzzer = st_ff.beep_on;
   assign o_top = st_ff.top;
   assign o_bot = st_ff.bot;
   assign o_bot_val = st_ff.bval;
   assign o_temp = st_ff.tval;
   assign o_time = st_ff.time_v;
   assign o_colon = st_ff.colon;
   assign o_par_idx = st_ff.idx;

   //////////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_OPEN_OFF: assert property (!i_sensor_ok |=> !o_relay)
      else $error("relay on without sensor");
   AST_OPEN_TEXT: assert property (!i_sensor_ok && st_ff.ui == UI_RUN |=> o_top == TOP_OPEN)
      else $error("open sensor text missing");
   AST_MASH_LAMP: assert property (!mash ##1 !mash |-> !o_mash_led)
      else $error("mash lamp lit in boil mode");
   AST_SKIP_ACCEL: assert property (st_ff.par[P_ATHR] == '0 && !mash |=> !st_ff.accel)
      else $error("acceleration not skipped");
   AST_ACCEL_FULL: assert property (st_ff.accel && i_sensor_ok && !mash && !st_ff.done
      && st_ff.par[P_AOUT] == PW'(PWM_SLOTS) |=> o_relay)
      else $error("acceleration output not full");
   AST_KNOB_BOUT: assert property (st_ff.ui == UI_RUN && !mash && i_knob_cw && !i_knob_fast
      && !i_nv_load && st_ff.par[P_BOUT] < PW'(PWM_SLOTS)
      |=> st_ff.par[P_BOUT] == $past(st_ff.par[P_BOUT]) + 1'b1 && o_nv_we)
      else $error("boil output not stepped");
   AST_HOLD_MENU: assert property (st_ff.ui == UI_RUN ##1 st_ff.ui == UI_GROUP
      |-> $past(st_ff.hold) >= 8'(HOLD_TK))
      else $error("menu entered before hold time");
   AST_TIMER_KEEP: assert property (st_ff.t_run && st_ff.par[P_TEN][0]
      && $signed(st_ff.elapsed) < dur_v |=> st_ff.t_run)
      else $error("timer stopped while counting");
   AST_END_BEEPS: assert property ($rose(st_ff.done) |-> st_ff.beeps == 3'(BEEP_END)
      && st_ff.beep_long)
      else $error("end beeps wrong");
   AST_ALARM_BEEPS: assert property (i_sensor_ok && temp > alm_v && !st_ff.above_q
      && !(st_ff.t_run && $signed(st_ff.elapsed) >= dur_v)
      |=> st_ff.beeps == 3'(BEEP_ALARM) && !st_ff.beep_long)
      else $error("alarm beeps wrong");
   AST_END_OFF: assert property (st_ff.done && !st_ff.par[P_BFIN][0] |=> !o_relay)
      else $error("output on after end");

   COV_ACCEL_END: cover property (st_ff.accel ##1 !st_ff.accel);
   COV_TIMER_DONE: cover property ($rose(st_ff.done));
   COV_MENU_EDIT: cover property (st_ff.ui == UI_GROUP ##1 st_ff.ui == UI_EDIT);
   COV_RESET_YES: cover property (st_ff.ui == UI_RST && st_ff.sel == SEL_YES && rise);
endmodule

// [tb/heater_sensor_model.sv]
// Model of the probe and the relay-driven heater on the far side of the block.
`timescale 1ns/100ps
module heater_sensor_model (
   input wire logic i_clk,                  // System clock.
   input wire logic i_relay,                // Relay drive from the block.
   input wire logic i_present,              // Probe fitted.
   input wire logic signed [11:0] i_set_c,  // Probe temperature, Celsius.
   output logic o_sensor_ok,                // Probe present level.
   output logic signed [11:0] o_temp_c,     // Probe reading.
   output int o_energy                      // Cycles with the heater on.
);
   initial
   begin
      o_energy = 0;
      o_temp_c = '0;
   end
   assign o_sensor_ok = i_present;
   // A missing probe gives a reading that flips every cycle between the last good one and its inverse.
   always @(posedge i_clk)
   begin
      o_temp_c <= i_present ? i_set_c : ~o_temp_c;
      o_energy <= o_energy + int'(i_relay);
   end
endmodule

// [tb/boil_power_regulator_timer_tb.sv]
// Self-checking bench of the boil power regulator.
`timescale 1ns/100ps
module boil_power_regulator_timer_tb import boil_pkg::*;;
   logic i_clk = 0, i_rst_n = 0, i_knob_cw = 0, i_knob_ccw = 0, i_knob_fast = 0;
   logic i_knob_press = 0, i_sensor_ok, i_nv_load = 0, present = 1, o_nv_we, o_relay;
   logic o_out_led, o_mash_led, o_buzzer, o_colon;
   logic signed [11:0] i_temp_c, set_c = 12'sh014;
   logic [3:0] i_nv_idx = '0, o_nv_idx, o_par_idx;
   logic [PW-1:0] i_nv_data = '0, o_nv_data, o_bot_val, o_temp, o_time;
   top_t o_top;
   bot_t o_bot;
   int energy, errors = 0, n_tests = 0, n, e;
   int rows [4][2] = '{'{0, 32}, '{-40, -40}, '{50, 122}, '{90, 194}};
   boil_power_regulator_timer #(.TICK_CYCLES(4), .SLOT_CYCLES(2)) DUT (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_knob_cw(i_knob_cw), .i_knob_ccw(i_knob_ccw),
      .i_knob_fast(i_knob_fast), .i_knob_press(i_knob_press), .i_sensor_ok(i_sensor_ok),
      .i_temp_c(i_temp_c), .i_nv_load(i_nv_load), .i_nv_idx(i_nv_idx), .i_nv_data(i_nv_data),
      .o_nv_we(o_nv_we), .o_nv_idx(o_nv_idx), .o_nv_data(o_nv_data), .o_relay(o_relay),
      .o_out_led(o_out_led), .o_mash_led(o_mash_led), .o_buzzer(o_buzzer), .o_top(o_top),
      .o_bot(o_bot), .o_bot_val(o_bot_val), .o_temp(o_temp), .o_time(o_time),
      .o_colon(o_colon), .o_par_idx(o_par_idx));
   heater_sensor_model partner (.i_clk(i_clk), .i_relay(o_relay), .i_present(present),
      .i_set_c(set_c), .o_sensor_ok(i_sensor_ok), .o_temp_c(i_temp_c), .o_energy(energy));
   initial
   begin
      forever #25 i_clk = ~i_clk;
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   task automatic step(input int k);
      repeat (k) @(posedge i_clk);
      #2;
   endtask
   task automatic check(input string what, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic knob(input logic ccw, input logic fast, input logic we);
      i_knob_cw = ~ccw;
      i_knob_ccw = ccw;
      i_knob_fast = fast;
      step(1);
      check("nv_we", o_nv_we, PW'(we));
      i_knob_cw = 0;
      i_knob_ccw = 0;
      i_knob_fast = 0;
      step(4);
   endtask
   // Relay on cycles over one full output window of 100 slots, after a settling window.
   task automatic power(input int exp);
      int e0;
      step(210);
      e0 = energy;
      step(200);
      check("relay_on", PW'(energy - e0), PW'(exp));
      if (exp == 200 || exp == 0)
         check("out_led", o_out_led, PW'(exp != 0));
   endtask
   // Counts buzzer onsets in n and cycles showing the end text in e.
   task automatic count_beeps(input int k);
      logic prev;
      prev = 0;
      n = 0;
      e = 0;
      repeat (k)
      begin
         step(1);
         n += int'(o_buzzer && !prev);
         e += int'(o_top == TOP_END);
         prev = o_buzzer;
      end
   endtask
   task automatic do_reset();
      i_rst_n = 0;
      step(8);
      i_rst_n = 1;
      step(1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #500_000;
      errors++;
      complete_run();
   end
   initial
   begin
      step(8);
      check("relay", o_relay, 0);
      check("top", o_top, TOP_TEMP);
      check("mash_led", o_mash_led, 0);
      i_rst_n = 1;
      step(1);
      $display("test reset done");
      foreach (rows[i])
      begin
         set_c = 12'(rows[i][0]);
         step(8);
         check("temp", o_temp, PW'(rows[i][1]));
         check("bot", o_bot, BOT_POWER);
         check("bot_val", o_bot_val, PW'(50));
      end
      $display("test display rows done");
      set_c = 12'sh014;
      power(200);
      knob(0, 0, 1);
      check("bot_val", o_bot_val, PW'(51));
      check("nv_idx", o_nv_idx, PW'(P_BOUT));
      check("nv_data", o_nv_data, PW'(51));
      power(200);
      $display("test acceleration done");
      set_c = 12'sh064;
      count_beeps(60);
      check("beeps", PW'(n), PW'(BEEP_ALARM));
      power(102);
      set_c = 12'sh014;
      knob(1, 1, 1);
      check("bot_val", o_bot_val, PW'(41));
      power(82);
      $display("test boil phase done");
      present = 0;
      step(8);
      check("top", o_top, TOP_OPEN);
      power(0);
      present = 1;
      $display("test open sensor done");
      i_knob_press = 1;
      step(230);
      check("top", o_top, TOP_GOTO);
      i_knob_press = 0;
      step(4);
      knob(0, 0, 0);
      check("bot", o_bot, BOT_GROUP);
      i_knob_press = 1;
      step(2);
      i_knob_press = 0;
      step(2);
      check("par_idx", o_par_idx, PW'(P_ATHR));
      check("top", o_top, TOP_PNAME);
      knob(0, 0, 1);
      check("bot_val", o_bot_val, PW'(201));
      $display("test long hold done");
      do_reset();
      i_nv_idx = 4'(P_ATHR);
      i_nv_data = '0;
      i_nv_load = 1;
      step(1);
      i_nv_load = 0;
      power(100);
      i_nv_idx = 4'(P_MODE);
      i_nv_data = PW'(1);
      i_nv_load = 1;
      step(1);
      i_nv_load = 0;
      step(6);
      check("mash_led", o_mash_led, 1);
      $display("test restore done");
      do_reset();
      i_nv_idx = 4'(P_BTIME);
      i_nv_data = PW'(1);
      i_nv_load = 1;
      step(1);
      i_nv_load = 0;
      set_c = 12'sh064;
      step(8);
      check("time", o_time, PW'(1));
      n = 0;
      e = 0;
      repeat (300)
      begin
         step(1);
         n += int'(o_top == TOP_TIME);
         e += int'(o_colon);
      end
      check("time_top", PW'(n > 0), PW'(1));
      check("colon", PW'(e > 0 && e < n), PW'(1));
      n = 0;
      while (o_time != '0 && n < 3000)
      begin
         step(1);
         n++;
      end
      check("time_end", o_time, 0);
      count_beeps(300);
      check("end_beeps", PW'(n), PW'(BEEP_END));
      check("end_top", PW'(e > 0), PW'(1));
      check("relay", o_relay, 0);
      $display("test timer done");
      i_knob_press = 1;
      step(2);
      i_knob_press = 0;
      step(2);
      check("bot", o_bot, BOT_NO);
      knob(0, 0, 0);
      check("bot", o_bot, BOT_YES);
      i_knob_press = 1;
      step(2);
      i_knob_press = 0;
      step(2);
      check("time", o_time, PW'(1));
      check("bot", o_bot, BOT_POWER);
      $display("test reset menu done");
      complete_run();
   end
endmodule
